// ### dual_role_session_timer.sv
/*
  dual-role session timer: 24-bit preload interval timer with a run bit,
  reached as two 16-bit halves with set and clear addresses over axi4-lite,
  with timeout edge events, sticky status, enable and one interrupt line.
  assumes a single 25 mhz clock and a well-behaved axi4-lite master.
*/
// Function
// - one 32-bit register as two halves
// - low half set F8h, clear FAh
// - high half set FCh, clear FEh
// - run bit one loads preload, starts counting
// - run bit cleared halts the counter
// - timeout clears run bit by itself
// - preload in bits 23:0, 30:24 reserved
// - counter advances every 0.01 ms tick
// - timeout edges raise events via bit-9 enables
`timescale 1ns/1ns
module dual_role_session_timer
  import dual_role_timer_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq
);

  logic                 aw_held_ff, w_held_ff, awready_ff, wready_ff;
  logic [ADDR_W-1:0]    awaddr_ff;
  logic [DATA_W-1:0]    wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]           bresp_ff, rresp_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic [HALF_W-1:0]    low_ff, high_ff, nxt_low, nxt_high;
  logic [PRELOAD_W-1:0] cnt_ff;
  logic [DIV_W-1:0]     div_ff;
  logic                 timeout_ff, prev_timeout_ff;
  logic                 rise_en_ff, fall_en_ff;
  logic [EV_W-1:0]      irq_status_ff, irq_enable_ff, nxt_status, events;
  logic                 irq_ff;
  logic                 wr_fire, hit_ls, hit_lc, hit_hs, hit_hc, wr_known;
  logic [IDX_W-1:0]     wr_idx;
  logic [HALF_W-1:0]    wdata16;
  logic                 run, start, stop, tick, timeout_evt;

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign irq     = irq_ff;

  // write address and data are taken in either order and held
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (awvalid && awready_ff) begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff  <= awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
    end else if (!aw_held_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (wvalid && wready_ff) begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff  <= wdata;
      wstrb_ff  <= wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
    end else if (!w_held_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // address decode of the held write; halves sit at index times four
  assign wr_idx   = awaddr_ff[ADDR_W-1:2];
  assign hit_ls   = wr_fire && wr_idx == IDX_LOW_SET;
  assign hit_lc   = wr_fire && wr_idx == IDX_LOW_CLR;
  assign hit_hs   = wr_fire && wr_idx == IDX_HIGH_SET;
  assign hit_hc   = wr_fire && wr_idx == IDX_HIGH_CLR;
  assign wr_known = hit_ls || hit_lc || hit_hs || hit_hc ||
                    awaddr_ff == ADDR_IRQ_CLEAR || awaddr_ff == ADDR_IRQ_ENABLE ||
                    awaddr_ff == ADDR_RISE_EN || awaddr_ff == ADDR_FALL_EN;
  assign wdata16  = wdata_ff[HALF_W-1:0] & {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // write response, unmapped writes answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // run control: set address with run bit starts, clear address halts
  assign run   = high_ff[RUN_BIT];
  assign start = hit_hs && wdata16[RUN_BIT];
  assign stop  = hit_hc && wdata16[RUN_BIT];
  assign tick  = run && div_ff == DIV_W'(TICK_DIV - 1);
  assign timeout_evt = tick && cnt_ff <= PRELOAD_W'(1) && !start && !stop;

  // next half contents: ones set or clear, zeros leave bits alone
  always_comb begin
    nxt_low  = (low_ff & ~(hit_lc ? wdata16 : HALF_RESET)) |
               (hit_ls ? wdata16 : HALF_RESET);
    nxt_high = ((high_ff & ~(hit_hc ? wdata16 : HALF_RESET)) |
                (hit_hs ? wdata16 : HALF_RESET)) & HIGH_WR_MASK;
    if (timeout_evt) begin
      nxt_high[RUN_BIT] = 1'b0;
    end
  end

  // the timer register itself, both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_ff  <= HALF_RESET;
      high_ff <= HALF_RESET;
    end else begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
    end
  end

  // tick divider, restarted on every start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
    end else if (start || !run || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // counter: load preload on start, count down one per tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= {nxt_high[PRELOAD_HI_W-1:0], low_ff};
    end else if (tick && !stop && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - PRELOAD_W'(1);
    end
  end

  // timeout status, cleared when a new interval starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_ff      <= 1'b0;
      prev_timeout_ff <= 1'b0;
    end else begin
      prev_timeout_ff <= timeout_ff;
      if (timeout_evt) begin
        timeout_ff <= 1'b1;
      end else if (start) begin
        timeout_ff <= 1'b0;
      end
    end
  end

  // edge events of the timeout status, selected by the edge enables
  assign events[EV_RISE] = rise_en_ff && timeout_ff && !prev_timeout_ff;
  assign events[EV_FALL] = fall_en_ff && !timeout_ff && prev_timeout_ff;
  assign nxt_status = (irq_status_ff &
                       ~((wr_fire && awaddr_ff == ADDR_IRQ_CLEAR) ?
                         wdata_ff[EV_W-1:0] : '0)) | events;

  // sticky status, enables and the interrupt line; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= '0;
      irq_enable_ff <= '0;
      rise_en_ff    <= 1'b0;
      fall_en_ff    <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      irq_status_ff <= nxt_status;
      irq_ff        <= |(nxt_status & irq_enable_ff);
      if (wr_fire && awaddr_ff == ADDR_IRQ_ENABLE && wstrb_ff[0]) begin
        irq_enable_ff <= wdata_ff[EV_W-1:0];
      end
      if (wr_fire && awaddr_ff == ADDR_RISE_EN && wstrb_ff[1]) begin
        rise_en_ff <= wdata_ff[EDGE_BIT];
      end
      if (wr_fire && awaddr_ff == ADDR_FALL_EN && wstrb_ff[1]) begin
        fall_en_ff <= wdata_ff[EDGE_BIT];
      end
    end
  end

  // read channel: one read at a time, answered the cycle after it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
      unique case (1'b1)
        araddr[ADDR_W-1:2] == IDX_LOW_SET,
        araddr[ADDR_W-1:2] == IDX_LOW_CLR: begin
          rdata_ff[HALF_W-1:0] <= low_ff;
        end
        araddr[ADDR_W-1:2] == IDX_HIGH_SET,
        araddr[ADDR_W-1:2] == IDX_HIGH_CLR: begin
          rdata_ff[HALF_W-1:0] <= high_ff;
        end
        araddr == ADDR_IRQ_STATUS: rdata_ff[EV_W-1:0] <= irq_status_ff;
        araddr == ADDR_IRQ_CLEAR:  rdata_ff <= '0;
        araddr == ADDR_IRQ_ENABLE: rdata_ff[EV_W-1:0] <= irq_enable_ff;
        araddr == ADDR_RISE_EN:    rdata_ff[EDGE_BIT] <= rise_en_ff;
        araddr == ADDR_FALL_EN:    rdata_ff[EDGE_BIT] <= fall_en_ff;
        araddr == ADDR_TIMER_STATE: begin
          rdata_ff[PRELOAD_W-1:0]   <= cnt_ff;
          rdata_ff[TIMEOUT_FLAG_BIT] <= timeout_ff;
        end
        default: rresp_ff <= RESP_SLVERR;
      endcase
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_low_set;
    hit_ls && !hit_lc |=> (low_ff & $past(wdata16)) == $past(wdata16);
  endproperty
  a_low_set: assert property (p_low_set) else $error("low set lost bits");

  property p_low_clr;
    hit_lc |=> (low_ff & $past(wdata16)) == HALF_RESET;
  endproperty
  a_low_clr: assert property (p_low_clr) else $error("low clear kept bits");

  property p_high_set;
    hit_hs |=> (high_ff & $past(wdata16) & HIGH_WR_MASK) ==
               ($past(wdata16) & HIGH_WR_MASK);
  endproperty
  a_high_set: assert property (p_high_set) else $error("high set lost bits");

  property p_reserved;
    (high_ff & ~HIGH_WR_MASK) == HALF_RESET;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_start;
    start |=> run && cnt_ff == {$past(nxt_high[PRELOAD_HI_W-1:0]), $past(low_ff)}
              && div_ff == '0 && !timeout_ff;
  endproperty
  a_start: assert property (p_start) else $error("start did not load");

  property p_stop;
    stop && !start |=> !run ##1 $stable(cnt_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");

  property p_timeout;
    timeout_evt |=> !run && timeout_ff && cnt_ff <= PRELOAD_W'(1);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not stop");

  property p_tick;
    tick && !start && !stop && cnt_ff > PRELOAD_W'(1) |=>
      cnt_ff == $past(cnt_ff) - PRELOAD_W'(1) && div_ff == '0;
  endproperty
  a_tick: assert property (p_tick) else $error("tick did not count");

  property p_rise_event;
    rise_en_ff && timeout_ff && !prev_timeout_ff |=> irq_status_ff[EV_RISE];
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rise event lost");

  property p_fall_event;
    fall_en_ff && !timeout_ff && prev_timeout_ff |=> irq_status_ff[EV_FALL];
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("fall event lost");

  property p_flag_source;
    $rose(timeout_ff) |-> $past(timeout_evt);
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("timeout without count");

  property p_irq;
    ##1 irq_ff == |($past(nxt_status) & $past(irq_enable_ff));
  endproperty
  a_irq: assert property (p_irq) else $error("irq line wrong");

  c_start:   cover property (start);
  c_timeout: cover property (timeout_evt);
  c_irq:     cover property ($rose(irq_ff));

endmodule

// ### dual_role_timer_pkg.sv
/*
  constants of the dual-role session timer: register indices and byte
  addresses, field positions, reset values and tick timing.
  assumes a 32-bit axi4-lite register bus and a 25 mhz block clock.
*/
package dual_role_timer_pkg;
  // bus shape
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 10;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // timer register halves: indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LOW_SET   = 10'h0f8;
  localparam logic [IDX_W-1:0] IDX_LOW_CLR   = 10'h0fa;
  localparam logic [IDX_W-1:0] IDX_HIGH_SET  = 10'h0fc;
  localparam logic [IDX_W-1:0] IDX_HIGH_CLR  = 10'h0fe;
  // block-local registers, byte addresses
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_RISE_EN    = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_FALL_EN    = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_STATE = 12'h014;
  // fields
  localparam int          HALF_W        = 16;
  localparam int          PRELOAD_W     = 24;
  localparam int          PRELOAD_HI_W  = 8;
  localparam int          RUN_BIT       = 15;   // bit 31 of the whole register
  localparam logic [15:0] HIGH_WR_MASK  = 16'h80ff;
  localparam logic [15:0] HALF_RESET    = 16'h0000;
  localparam int          EDGE_BIT      = 9;
  localparam int          EV_RISE       = 0;
  localparam int          EV_FALL       = 1;
  localparam int          EV_W          = 2;
  localparam int          TIMEOUT_FLAG_BIT = 31;
  // tick timing
  localparam int          TICK_TIME_NS  = 10000;  // 0.01 ms
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int          DIV_W         = 12;
endpackage

// ### dual_role_session_timer_bench.sv
/*
  self-checking bench of the dual-role session timer: axi4-lite master
  tasks, a monitor that checks responses against queues of expected ones.
  assumes the design package and a short tick divider of 4 cycles.
*/
`timescale 1ns/1ns
module dual_role_session_timer_bench
  import dual_role_timer_pkg::*;
;
  localparam int DIV = 4;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = 4'hf;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              irq;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [31:0]       seed = 32'he08cbfe4;
  int                mismatches = 0;
  int                compares = 0;
  int                n;
  int                cyc;
  logic [15:0]       r16;

  dual_role_session_timer #(.TICK_DIV(DIV)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
  );

  // 25 mhz clock
  always #20 aclk = ~aclk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // monitor: oldest expected response against each handshake
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) chk({rresp, rdata}, 34'h3ffffffff);
      else chk({rresp, rdata}, rq.pop_front());
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) chk({32'h0, bresp}, 34'h3);
      else chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
  end

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hf);
    int k;
    @(posedge aclk);
    bq.push_back(er);
    awaddr <= a;
    wstrb <= s;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && k < 200);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // read: expected word noted before the request goes out
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int k;
    @(posedge aclk);
    rq.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && k < 200);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h3e0, 32'h0);
    rd(12'h3f8, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h0);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(12'h104, 32'hffffffff, RESP_SLVERR);
    // set and clear of the low half, random pattern
    seed = xorshift(seed);
    r16 = seed[15:0];
    wr(12'h3e0, {16'h0, r16});
    rd(12'h3e0, {16'h0, r16});
    rd(12'h3e8, {16'h0, r16});
    wr(12'h3e8, 32'h00ff);
    rd(12'h3e0, {16'h0, r16 & 16'hff00});
    // byte lane 0 alone sets only the low byte of the half
    wr(12'h3e8, 32'hffff);
    wr(12'h3e0, 32'hffff, RESP_OKAY, 4'h1);
    rd(12'h3e0, 32'h00ff);
    // high half: reserved bits stay zero
    wr(12'h3f0, 32'h7fff);
    rd(12'h3f8, 32'h00ff);
    wr(12'h3f8, 32'hffff);
    rd(12'h3f0, 32'h0);
    // both edge enables, and irq enable for the rise event only
    wr(ADDR_RISE_EN, 32'h200, RESP_OKAY, 4'h1);
    rd(ADDR_RISE_EN, 32'h0);
    wr(ADDR_RISE_EN, 32'h200);
    rd(ADDR_RISE_EN, 32'h200);
    wr(ADDR_FALL_EN, 32'h200);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    seed = xorshift(seed);
    n = 8 + int'(seed[2:0]);
    wr(12'h3e8, 32'hffff);
    wr(12'h3e0, n);
    wr(12'h3f0, 32'h8000);
    cyc = 0;
    rd(12'h3f0, 32'h8000);
    cyc = cyc + 4;
    while (irq !== 1'b1 && cyc < n * DIV + 40) begin
      @(posedge aclk);
      cyc++;
    end
    chk(cyc >= n * DIV - 3 && cyc <= n * DIV + 4, 34'h1);
    // a missed timeout was counted above; stop the run there
    if (irq !== 1'b1) begin
      tally_and_finish();
    end
    rd(12'h3f0, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h1);
    rd(ADDR_TIMER_STATE, 32'h80000000);
    // start clears the flag (fall event), then halt before timeout
    wr(ADDR_IRQ_CLEAR, 32'h3);
    wr(12'h3f0, 32'h8000);
    wr(12'h3f8, 32'h8000);
    repeat (n * DIV + 16) @(posedge aclk);
    rd(12'h3f0, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    chk({33'h0, irq}, 34'h0);
    wr(ADDR_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h1);
    wr(ADDR_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h0);
    rd(ADDR_IRQ_STATUS, 32'h0);
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule
